// file: safety_map.vh
// Register offsets, field positions, reset values and timing for the safety config block
`ifndef SAFETY_MAP_VH
`define SAFETY_MAP_VH

`define ADDR_SAFETY_TWO 8'h00
`define ADDR_SAFETY_THREE 8'h04
`define ADDR_ALARM_MASK 8'h08
`define ADDR_MOTOR_SETUP 8'h0C
`define ADDR_CONTROL 8'h10
`define ADDR_STATUS 8'h14

`define RST_SAFETY_TWO 8'h00
`define RST_SAFETY_THREE 8'h00
`define RST_ALARM_MASK 8'h00
`define RST_MOTOR_SETUP 8'h03
`define RST_CONTROL 8'h00

// safety_setting_two
`define S2_SPECIAL_FORBID_Z 7
`define S2_SPECIAL_FORBID_X 6
`define S2_SPECIAL_FORBID_Y 5
`define S2_RESET_KEEPS_SPECIAL 4
`define S2_ESTOP_ALL_AUX 3
`define S2_RESET_KEEPS_AUX 2
`define S2_AUX_ALARM_RETRY 1
`define S2_THREAD_WAIT 0
// safety_setting_three
`define S3_DRIVE_ALARM_SPINDLE_OFF 7
`define S3_STATE_CHANGE_PROMPT 6
// alarm_debug_mask
`define M_ESTOP 7
`define M_HW_LIMIT 6
`define M_DRIVE 5
`define M_MACH_SOFT 4
`define M_TOOL_SOFT 3
`define M_CUSTOM_MOTION_OK 2
`define M_HW_LIMIT_HIGH 1
`define M_PROG254_WRITE_OK 0
// motor_drive_setup
`define MD_DIR_Z 7
`define MD_DIR_X 6
`define MD_DIR_Y 5
`define MD_DRV_POL_Z 4
`define MD_DRV_POL_X 3
`define MD_DRV_POL_Y 2
`define MD_HAS_Y 1
`define MD_HAS_X 0
// control register
`define CTL_MULTI_CMD_ORDER 0

// Auxiliary output vector positions
`define AUX_SPINDLE_FWD 0
`define AUX_SPINDLE_REV 1
`define AUX_COOLANT 2
`define AUX_LUBE 3
`define AUX_EXTRA 4
// Outputs dropped on an emergency stop when only the basic set goes off
`define AUX_ESTOP_BASIC 8'h0F
// Outputs dropped by the reset key, then the spindle pair dropped on a drive alarm
`define AUX_RESET_SET 8'h17
`define AUX_SPINDLE_SET 8'h03

`define PROG_CUSTOM_TABLE 8'hFE
`define AUX_TIMEOUT_DEFAULT 1000

`endif

// file: sync_two.v
// Two-stage level synchroniser for asynchronous inputs
`timescale 1ns/10ps
module sync_two #(
	parameter W = 1
) (
	input wire pclk,
	input wire presetn,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;
endmodule

// file: safety_alarm_config.v
// Safety configuration, alarm qualification and auxiliary output control
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "safety_map.vh"
module safety_alarm_config #(
	parameter AUX_TIMEOUT_CYC = `AUX_TIMEOUT_DEFAULT
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire estop_n_in,
	input wire hw_limit_in,
	input wire [2:0] drive_alarm_in,
	input wire mach_soft_limit_hit,
	input wire tool_soft_limit_hit,
	input wire reset_key,
	input wire cycle_start_key,
	input wire retry_key,
	input wire escape_key,
	input wire yes_key,
	input wire no_key,
	input wire halt_event,
	input wire [7:0] aux_on,
	input wire [7:0] aux_off,
	input wire chuck_clamped,
	input wire tailstock_advanced,
	input wire [2:0] special_start,
	input wire [2:0] special_done,
	input wire [2:0] axis_dir_cmd,
	input wire [2:0] move_req,
	input wire thread_req,
	input wire spindle_stable,
	input wire aux_cmd_start,
	input wire aux_confirm,
	input wire custom_motion_req,
	input wire custom_motion_is_dwell,
	input wire [7:0] prog_write_num,
	input wire prog_write_req,
	input wire block_cmd_req,
	input wire block_cmd_done,
	output reg [7:0] aux_out,
	output reg [2:0] special_run,
	output reg [2:0] motor_dir,
	output reg [2:0] move_grant,
	output reg [2:0] move_reject,
	output reg thread_go,
	output reg estop_alarm,
	output reg hw_limit_alarm,
	output reg drive_alarm,
	output reg soft_limit_alarm,
	output reg retry_prompt,
	output reg program_pause,
	output reg program_abort,
	output reg aux_cmd_ok,
	output reg state_prompt,
	output reg custom_reject,
	output reg prog_write_grant,
	output reg prog_write_deny,
	output reg block_cmd_grant
);
	localparam ST_IDLE = 3'd0;
	localparam ST_WAIT = 3'd1;
	localparam ST_PROMPT = 3'd2;
	localparam ST_RERUN = 3'd3;
	localparam ST_PAUSE = 3'd4;

	reg [7:0] safety_two_q;
	reg [7:0] safety_three_q;
	reg [7:0] alarm_mask_q;
	reg [7:0] motor_setup_q;
	reg [7:0] control_q;
	reg [2:0] fsm_q;
	reg [2:0] fsm_d;
	reg [31:0] timer_q;
	reg thread_pend_q;
	reg [3:0] snapshot_q;
	reg snap_valid_q;
	reg block_busy_q;
	reg [7:0] kill_mask;
	reg [31:0] rd_word;
	reg rd_hit;
	wire estop_hit_s;
	wire hw_limit_ns;
	wire [2:0] drive_ns;
	wire setup_ph;
	wire wr_en;
	wire timed_out;
	wire estop_act;
	wire hw_act;
	wire drive_act;
	wire soft_act;
	wire [2:0] forbid;
	wire [3:0] live_state;

	// Register index decode, shared by read and write paths
	function [2:0] reg_sel;
		input [7:0] a;
		begin
			case (a)
				`ADDR_SAFETY_TWO: reg_sel = 3'd1;
				`ADDR_SAFETY_THREE: reg_sel = 3'd2;
				`ADDR_ALARM_MASK: reg_sel = 3'd3;
				`ADDR_MOTOR_SETUP: reg_sel = 3'd4;
				`ADDR_CONTROL: reg_sel = 3'd5;
				`ADDR_STATUS: reg_sel = 3'd6;
				default: reg_sel = 3'd0;
			endcase
		end
	endfunction

	// Alarm inputs come straight from machine wiring; never act on a raw level.
	// Inverted on the way in so the cleared synchroniser reads as idle pins after reset.
	sync_two #(.W(5)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({~estop_n_in, ~hw_limit_in, ~drive_alarm_in}),
		.dout({estop_hit_s, hw_limit_ns, drive_ns})
	);

	// Emergency stop uses a normally closed contact, so a low level is the alarm
	assign estop_act = ~alarm_mask_q[`M_ESTOP] & estop_hit_s;
	assign hw_act = ~alarm_mask_q[`M_HW_LIMIT] &
		(alarm_mask_q[`M_HW_LIMIT_HIGH] ? ~hw_limit_ns : hw_limit_ns);
	assign drive_act = ~alarm_mask_q[`M_DRIVE] & |(drive_ns ^ {
		motor_setup_q[`MD_DRV_POL_Z], motor_setup_q[`MD_DRV_POL_X],
		motor_setup_q[`MD_DRV_POL_Y]});
	assign soft_act = (mach_soft_limit_hit & ~alarm_mask_q[`M_MACH_SOFT]) |
		(tool_soft_limit_hit & ~alarm_mask_q[`M_TOOL_SOFT]);
	assign forbid = {safety_two_q[`S2_SPECIAL_FORBID_Z], safety_two_q[`S2_SPECIAL_FORBID_X],
		safety_two_q[`S2_SPECIAL_FORBID_Y]};
	assign live_state = {tailstock_advanced, chuck_clamped,
		aux_out[`AUX_SPINDLE_REV], aux_out[`AUX_SPINDLE_FWD]};

	assign setup_ph = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign timed_out = (timer_q == 32'h00000000);

	// APB answers in the access cycle right after setup: no wait states
	always @* begin
		rd_hit = 1'b1;
		rd_word = 32'h00000000;
		case (reg_sel(paddr))
			3'd1: rd_word = {24'h000000, safety_two_q};
			3'd2: rd_word = {24'h000000, safety_three_q};
			3'd3: rd_word = {24'h000000, alarm_mask_q};
			3'd4: rd_word = {24'h000000, motor_setup_q};
			3'd5: rd_word = {24'h000000, control_q};
			3'd6: rd_word = {10'h000, special_run, fsm_q, snap_valid_q, state_prompt,
				block_busy_q, thread_pend_q, soft_limit_alarm, drive_alarm,
				hw_limit_alarm, estop_alarm, aux_out};
			default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph & ~rd_hit;
			prdata <= (setup_ph & ~pwrite) ? rd_word : 32'h00000000;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			safety_two_q <= `RST_SAFETY_TWO;
			safety_three_q <= `RST_SAFETY_THREE;
			alarm_mask_q <= `RST_ALARM_MASK;
			motor_setup_q <= `RST_MOTOR_SETUP;
			control_q <= `RST_CONTROL;
		end else if (wr_en) begin
			case (reg_sel(paddr))
				3'd1: safety_two_q <= pwdata[7:0];
				3'd2: safety_three_q <= {pwdata[7:6], 6'h00};
				3'd3: alarm_mask_q <= pwdata[7:0];
				3'd4: motor_setup_q <= pwdata[7:0];
				3'd5: control_q <= {7'h00, pwdata[0]};
				default: control_q <= control_q;
			endcase
		end
	end

	// Alarms and soft limits are registered levels
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			estop_alarm <= 1'b0;
			hw_limit_alarm <= 1'b0;
			drive_alarm <= 1'b0;
			soft_limit_alarm <= 1'b0;
		end else begin
			estop_alarm <= estop_act;
			hw_limit_alarm <= hw_act;
			drive_alarm <= drive_act;
			soft_limit_alarm <= soft_act;
		end
	end

	// Safety drops always win over a same-cycle switch-on request
	always @* begin
		kill_mask = 8'h00;
		if (estop_act)
			kill_mask = kill_mask | (safety_two_q[`S2_ESTOP_ALL_AUX] ?
				8'hFF : `AUX_ESTOP_BASIC);
		if (reset_key & ~safety_two_q[`S2_RESET_KEEPS_AUX])
			kill_mask = kill_mask | `AUX_RESET_SET;
		if (drive_act & safety_three_q[`S3_DRIVE_ALARM_SPINDLE_OFF])
			kill_mask = kill_mask | `AUX_SPINDLE_SET;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_out <= 8'h00;
		end else begin
			aux_out <= (aux_out | aux_on) & ~aux_off & ~kill_mask;
		end
	end

	// Special motion per axis
	genvar ax;
	generate
		for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					special_run[ax] <= 1'b0;
				end else if (special_done[ax] | estop_act |
					(reset_key & ~safety_two_q[`S2_RESET_KEEPS_SPECIAL])) begin
					special_run[ax] <= 1'b0;
				end else if (special_start[ax] & ~forbid[ax]) begin
					special_run[ax] <= 1'b1;
				end
			end
		end
	endgenerate

	// Axis order in vectors is {Z, X, Y}
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motor_dir <= 3'b000;
			move_grant <= 3'b000;
			move_reject <= 3'b000;
		end else begin
			motor_dir <= axis_dir_cmd ^ {motor_setup_q[`MD_DIR_Z],
				motor_setup_q[`MD_DIR_X], motor_setup_q[`MD_DIR_Y]};
			move_grant <= move_req & {1'b1, motor_setup_q[`MD_HAS_X],
				motor_setup_q[`MD_HAS_Y]};
			move_reject <= move_req & {1'b0, ~motor_setup_q[`MD_HAS_X],
				~motor_setup_q[`MD_HAS_Y]};
		end
	end

	// A stale stable flag right after a speed change is the program's hazard
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thread_pend_q <= 1'b0;
			thread_go <= 1'b0;
		end else begin
			thread_go <= 1'b0;
			if (thread_req | thread_pend_q) begin
				if (~safety_two_q[`S2_THREAD_WAIT] | spindle_stable) begin
					thread_go <= 1'b1;
					thread_pend_q <= 1'b0;
				end else begin
					thread_pend_q <= 1'b1;
				end
			end
		end
	end

	// Tool, chuck and tailstock command supervision
	always @* begin
		fsm_d = fsm_q;
		case (fsm_q)
			ST_IDLE: begin
				if (aux_cmd_start)
					fsm_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (aux_confirm)
					fsm_d = ST_IDLE;
				else if (timed_out)
					fsm_d = (safety_two_q[`S2_AUX_ALARM_RETRY] &
						~control_q[`CTL_MULTI_CMD_ORDER]) ? ST_PROMPT : ST_IDLE;
			end
			ST_PROMPT: begin
				if (escape_key)
					fsm_d = ST_IDLE;
				else if (retry_key)
					fsm_d = ST_RERUN;
			end
			ST_RERUN: begin
				if (aux_confirm)
					fsm_d = ST_PAUSE;
				else if (timed_out)
					fsm_d = ST_PROMPT;
			end
			ST_PAUSE: begin
				if (cycle_start_key | escape_key)
					fsm_d = ST_IDLE;
			end
			default: fsm_d = ST_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fsm_q <= ST_IDLE;
			timer_q <= 32'h00000000;
			retry_prompt <= 1'b0;
			program_pause <= 1'b0;
			program_abort <= 1'b0;
			aux_cmd_ok <= 1'b0;
		end else begin
			fsm_q <= fsm_d;
			if (fsm_d != fsm_q)
				timer_q <= AUX_TIMEOUT_CYC - 1;
			else if (!timed_out)
				timer_q <= timer_q - 32'h00000001;
			retry_prompt <= (fsm_d == ST_PROMPT);
			program_pause <= (fsm_d == ST_PROMPT) | (fsm_d == ST_PAUSE);
			program_abort <= ((fsm_q == ST_WAIT) & ~aux_confirm & timed_out &
				(fsm_d == ST_IDLE)) | (escape_key & ((fsm_q == ST_PROMPT) |
				(fsm_q == ST_PAUSE))) | (state_prompt & no_key);
			aux_cmd_ok <= ((fsm_q == ST_WAIT) & aux_confirm) |
				((fsm_q == ST_PAUSE) & cycle_start_key & ~escape_key);
		end
	end

	// Spindle, chuck and tailstock snapshot compared at cycle start
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snapshot_q <= 4'h0;
			snap_valid_q <= 1'b0;
			state_prompt <= 1'b0;
		end else begin
			// Clear first so a new mismatch in the same cycle wins
			if (state_prompt & (yes_key | no_key))
				state_prompt <= 1'b0;
			if (halt_event & safety_three_q[`S3_STATE_CHANGE_PROMPT]) begin
				snapshot_q <= live_state;
				snap_valid_q <= 1'b1;
			end else if (cycle_start_key & snap_valid_q) begin
				snap_valid_q <= 1'b0;
				if (snapshot_q != live_state)
					state_prompt <= 1'b1;
			end
		end
	end

	// Custom block contents, program 254 protection and block sequencing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			custom_reject <= 1'b0;
			prog_write_grant <= 1'b0;
			prog_write_deny <= 1'b0;
			block_busy_q <= 1'b0;
			block_cmd_grant <= 1'b0;
		end else begin
			custom_reject <= custom_motion_req & ~custom_motion_is_dwell &
				~alarm_mask_q[`M_CUSTOM_MOTION_OK];
			prog_write_deny <= prog_write_req & (prog_write_num == `PROG_CUSTOM_TABLE) &
				~alarm_mask_q[`M_PROG254_WRITE_OK];
			prog_write_grant <= prog_write_req & ((prog_write_num != `PROG_CUSTOM_TABLE) |
				alarm_mask_q[`M_PROG254_WRITE_OK]);
			block_cmd_grant <= block_cmd_req & (control_q[`CTL_MULTI_CMD_ORDER] |
				~block_busy_q | block_cmd_done);
			if (block_cmd_req & ~control_q[`CTL_MULTI_CMD_ORDER] &
				(~block_busy_q | block_cmd_done))
				block_busy_q <= 1'b1;
			else if (block_cmd_done)
				block_busy_q <= 1'b0;
		end
	end
endmodule

// file: machine_side_model.sv
// Machine-side model: stop contact, limit switch, drives, actuator confirm and spindle
`timescale 1ns/10ps
module machine_side_model (
	input wire pclk,
	input wire estop_press,
	input wire limit_fault,
	input wire limit_high,
	input wire [2:0] drive_fault,
	input wire [2:0] drive_high,
	input wire confirm_en,
	input wire speed_change,
	output wire estop_n_in,
	output wire hw_limit_in,
	output wire [2:0] drive_alarm_in,
	output reg aux_confirm,
	output wire spindle_stable
);
	reg [3:0] settle_q = 4'h0;
	// Normally closed contact: pressing opens the loop
	assign estop_n_in = ~estop_press;
	assign hw_limit_in = limit_fault ~^ limit_high;
	assign drive_alarm_in = drive_fault ~^ drive_high;
	// Spindle ramps for eight cycles after a speed change, then reads stable
	assign spindle_stable = (settle_q == 4'h0);
	always @(posedge pclk) begin
		aux_confirm <= confirm_en;
		settle_q <= speed_change ? 4'h8 : settle_q - (settle_q != 4'h0);
	end
endmodule

// file: safety_alarm_config_sva.sv
// Assertion checker for the safety configuration block, with its bind
`timescale 1ns/10ps
`include "safety_map.vh"
module safety_alarm_config_sva #(
	parameter AUX_TIMEOUT_CYC = `AUX_TIMEOUT_DEFAULT
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire estop_n_in,
	input wire hw_limit_in,
	input wire [2:0] drive_alarm_in,
	input wire reset_key,
	input wire [2:0] move_req,
	input wire [7:0] prog_write_num,
	input wire prog_write_req,
	input wire [7:0] aux_out,
	input wire [2:0] move_grant,
	input wire [2:0] move_reject,
	input wire estop_alarm,
	input wire hw_limit_alarm,
	input wire drive_alarm,
	input wire prog_write_grant,
	input wire prog_write_deny
);
	reg [7:0] s2_q, s3_q, mk_q, md_q;
	// Shadow settings, taken from completed writes only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s2_q <= `RST_SAFETY_TWO;
			s3_q <= `RST_SAFETY_THREE;
			mk_q <= `RST_ALARM_MASK;
			md_q <= `RST_MOTOR_SETUP;
		end else if (psel && penable && pready && pwrite) begin
			case (paddr)
				`ADDR_SAFETY_TWO: s2_q <= pwdata[7:0];
				`ADDR_SAFETY_THREE: s3_q <= pwdata[7:0];
				`ADDR_ALARM_MASK: mk_q <= pwdata[7:0];
				`ADDR_MOTOR_SETUP: md_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_apb_ready;
		psel && !penable |=> pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
	property p_estop;
		(!estop_n_in && !mk_q[`M_ESTOP])[*3] |=> estop_alarm;
	endproperty
	a_estop: assert property (p_estop) else $error("stop alarm missed");
	property p_estop_mask;
		mk_q[`M_ESTOP][*3] |-> !estop_alarm;
	endproperty
	a_estop_mask: assert property (p_estop_mask) else $error("masked stop seen");
	property p_hw_limit;
		((hw_limit_in == mk_q[`M_HW_LIMIT_HIGH]) && !mk_q[`M_HW_LIMIT])[*3] |=> hw_limit_alarm;
	endproperty
	a_hw_limit: assert property (p_hw_limit) else $error("limit alarm missed");
	property p_drive;
		((drive_alarm_in[2] == md_q[`MD_DRV_POL_Z]) && !mk_q[`M_DRIVE])[*3] |=> drive_alarm;
	endproperty
	a_drive: assert property (p_drive) else $error("drive alarm missed");
	property p_spindle_kill;
		drive_alarm && s3_q[`S3_DRIVE_ALARM_SPINDLE_OFF] |=> (aux_out & `AUX_SPINDLE_SET) == 8'h00;
	endproperty
	a_spindle_kill: assert property (p_spindle_kill) else $error("spindle left on");
	property p_reset_aux;
		reset_key && !s2_q[`S2_RESET_KEEPS_AUX] |=> (aux_out & `AUX_RESET_SET) == 8'h00;
	endproperty
	a_reset_aux: assert property (p_reset_aux) else $error("reset left outputs on");
	property p_move_y;
		move_req[0] && !md_q[`MD_HAS_Y] |=> move_reject[0] && !move_grant[0];
	endproperty
	a_move_y: assert property (p_move_y) else $error("absent axis moved");
	property p_prog_lock;
		prog_write_req && prog_write_num == `PROG_CUSTOM_TABLE && !mk_q[0]
			|=> prog_write_deny && !prog_write_grant;
	endproperty
	a_prog_lock: assert property (p_prog_lock) else $error("locked program written");
	c_estop: cover property ($rose(estop_alarm));
	c_drive: cover property ($rose(drive_alarm));
	c_reject: cover property (move_reject[0]);
endmodule
bind safety_alarm_config safety_alarm_config_sva #(.AUX_TIMEOUT_CYC(AUX_TIMEOUT_CYC)) sva_i (.*);

// file: machine_safety_alarm_config_tb.sv
// Self-checking bench for the safety configuration and alarm block
`timescale 1ns/10ps
`include "safety_map.vh"
`define CHK(nm, ex, got) begin \
	check_count++; \
	if ((got) !== (ex)) begin \
		num_errors++; \
		$display("mismatch %s exp %h got %h", nm, ex, got); \
	end \
end
`define PULSE(s, v) begin \
	@(posedge pclk); \
	s <= v; \
	@(posedge pclk); \
	s <= 0; \
	@(negedge pclk); \
end
`define WAITFOR(s) begin \
	n = 0; \
	while (s !== 1'b1 && n < 60) begin \
		n++; \
		@(negedge pclk); \
	end \
	if (n >= 60) num_errors++; \
end
module machine_safety_alarm_config_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0, aux_on = 0, aux_off = 0, prog_write_num = 0;
	logic [31:0] pwdata = 0, rd;
	logic reset_key = 0, cycle_start_key = 0, retry_key = 0, escape_key = 0, yes_key = 0;
	logic no_key = 0, halt_event = 0, chuck_clamped = 0, thread_req = 0, aux_cmd_start = 0;
	logic custom_motion_req = 0, custom_motion_is_dwell = 0, prog_write_req = 0;
	logic mach_soft_limit_hit = 0;
	wire soft_limit_alarm, prog_write_grant;
	logic estop_press = 0, limit_fault = 0, limit_high = 0, confirm_en = 0, speed_change = 0;
	logic [2:0] special_start = 0, special_done = 0, axis_dir_cmd = 0, move_req = 0;
	logic [2:0] drive_fault = 0, drive_high = 0;
	wire [31:0] prdata;
	wire [7:0] aux_out;
	wire [2:0] special_run, motor_dir, move_grant, move_reject, drive_alarm_in;
	wire pready, pslverr, thread_go, estop_alarm, hw_limit_alarm, drive_alarm, retry_prompt;
	wire program_pause, program_abort, aux_cmd_ok, prog_write_deny, custom_reject, estop_n_in;
	wire hw_limit_in, aux_confirm, spindle_stable, state_prompt;
	int num_errors = 0, check_count = 0, n;
	safety_alarm_config #(.AUX_TIMEOUT_CYC(20)) safety_alarm_config_i (.*,
		.tool_soft_limit_hit(1'b0), .tailstock_advanced(1'b0),
		.block_cmd_req(1'b0), .block_cmd_done(1'b0), .block_cmd_grant());
	machine_side_model machine_side_model_i (.*);
	always #5 pclk = ~pclk;
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(negedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(negedge pclk);
		end
		if (k >= 20)
			num_errors++;
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		apb(`ADDR_MOTOR_SETUP, 0, 0);
		`CHK("motor reset", {24'h0, `RST_MOTOR_SETUP}, rd)
		apb(8'h20, 0, 0);
		`CHK("unmapped", 1'b1, err)
		apb(`ADDR_SAFETY_THREE, 1, 32'hFF);
		apb(`ADDR_SAFETY_THREE, 0, 0);
		`CHK("setting three", 32'hC0, rd)
		`PULSE(move_req, 3'b111)
		`CHK("grant", 3'b111, move_grant)
		apb(`ADDR_MOTOR_SETUP, 1, 32'hE0);
		axis_dir_cmd <= 3'b101;
		`PULSE(move_req, 3'b111)
		`CHK("reject", 3'b011, move_reject)
		`CHK("direction", 3'b010, motor_dir)
		for (int b = 0; b < 2; b++) begin
			apb(`ADDR_SAFETY_TWO, 1, b ? 32'h08 : 32'h00);
			`PULSE(aux_on, 8'hFF)
			@(posedge pclk);
			estop_press <= 1;
			repeat (5) @(posedge pclk);
			`CHK("stop alarm", 1'b1, estop_alarm)
			`CHK("stop outputs", b ? 8'h00 : 8'hF0, aux_out)
			estop_press <= 0;
			repeat (5) @(posedge pclk);
			apb(`ADDR_SAFETY_TWO, 1, b ? 32'h14 : 32'h80);
			`PULSE(aux_on, 8'hFF)
			`PULSE(special_start, 3'b101)
			`CHK("special", b ? 3'b101 : 3'b001, special_run)
			`PULSE(reset_key, 1'b1)
			`CHK("special reset", b ? 3'b101 : 3'b000, special_run)
			`CHK("reset outputs", b ? 8'hFF : 8'hE8, aux_out)
		end
		`PULSE(aux_off, 8'hFF)
		apb(`ADDR_ALARM_MASK, 1, 32'h80);
		estop_press <= 1;
		limit_fault <= 1;
		drive_fault <= 3'b100;
		`PULSE(aux_on, 8'h03)
		repeat (5) @(posedge pclk);
		`CHK("masked stop", 1'b0, estop_alarm)
		`CHK("limit", 1'b1, hw_limit_alarm)
		`CHK("drive", 1'b1, drive_alarm)
		`CHK("spindle off", 8'h00, aux_out)
		estop_press <= 0;
		limit_fault <= 0;
		drive_fault <= 0;
		apb(`ADDR_ALARM_MASK, 1, 32'h00);
		apb(`ADDR_SAFETY_TWO, 1, 32'h03);
		`PULSE(speed_change, 1'b1)
		`PULSE(thread_req, 1'b1)
		`CHK("thread held", 1'b0, thread_go)
		`WAITFOR(thread_go)
		`CHK("thread go", 1'b1, thread_go)
		`PULSE(aux_cmd_start, 1'b1)
		`WAITFOR(retry_prompt)
		`CHK("pause", 1'b1, program_pause)
		@(posedge pclk);
		confirm_en <= 1;
		`PULSE(retry_key, 1'b1)
		repeat (4) @(posedge pclk);
		`CHK("rerun pause", 2'b01, {retry_prompt, program_pause})
		`PULSE(cycle_start_key, 1'b1)
		`CHK("resume", 1'b1, aux_cmd_ok)
		@(posedge pclk);
		confirm_en <= 0;
		`PULSE(aux_cmd_start, 1'b1)
		`WAITFOR(retry_prompt)
		`PULSE(escape_key, 1'b1)
		`CHK("escape", 1'b1, program_abort)
		apb(`ADDR_SAFETY_TWO, 1, 32'h00);
		`PULSE(aux_cmd_start, 1'b1)
		`WAITFOR(program_abort)
		`CHK("abort", 1'b1, program_abort)
		`PULSE(halt_event, 1'b1)
		@(posedge pclk);
		chuck_clamped <= 1;
		`PULSE(cycle_start_key, 1'b1)
		`CHK("state prompt", 1'b1, state_prompt)
		`PULSE(yes_key, 1'b1)
		`CHK("state cleared", 1'b0, state_prompt)
		@(posedge pclk);
		prog_write_num <= `PROG_CUSTOM_TABLE;
		`PULSE(prog_write_req, 1'b1)
		`CHK("prog lock", 1'b1, prog_write_deny)
		`PULSE(custom_motion_req, 1'b1)
		`CHK("custom", 1'b1, custom_reject)
		`PULSE(mach_soft_limit_hit, 1'b1)
		`CHK("soft limit", 1'b1, soft_limit_alarm)
		apb(`ADDR_ALARM_MASK, 1, 32'h11);
		`PULSE(mach_soft_limit_hit, 1'b1)
		`CHK("soft masked", 1'b0, soft_limit_alarm)
		`PULSE(prog_write_req, 1'b1)
		`CHK("prog open", 1'b1, prog_write_grant)
		close_out();
	end
endmodule
